// [sim/nvc_dev_model.sv]
// device model: 8Kx8 static memory with a nonvolatile shadow copy
`timescale 1ns/1ps
module nvc_dev_model #(
	parameter int SAVE_CYC = 40,
	parameter int REST_CYC = 15
) (
	input  wire logic               clk,
	input  wire nvc_pkg::nvc_pins_t pins,
	input  wire logic [7:0]         wdata,
	input  wire logic               wdata_oe,
	input  wire logic               line,
	output logic [7:0]              bus,
	output logic                    pull
);
	// ==========================================
	// storage and state
	logic [7:0]  mem [8192];
	logic [7:0]  nvm [8192];
	logic [12:0] keys [5] = '{nvc_pkg::KEY0, nvc_pkg::KEY1,
		nvc_pkg::KEY2, nvc_pkg::KEY3, nvc_pkg::KEY4};
	logic        dirty = 0, inh = 0, wfirst = 0, pcs = 1, hw = 0, tog = 0;
	int          busy = 0, kpos = 0, saves = 0, rests = 0;
	wire  [12:0] a = pins.byte_addr;
	wire         cs = !pins.chip_sel_n;
	// released lines toggle so that stale data never looks valid
	wire drv = cs && !pins.out_en_n && pins.write_n && line && busy == 0
		&& !inh && !wfirst; // clean read only
	assign bus  = drv ? mem[a] : wdata_oe ? wdata : {8{tog}};
	assign pull = hw && busy != 0; // busy held low only during a hardware save
	// both copies start cleared
	initial foreach (mem[i]) begin
		mem[i] = 8'h00;
		nvm[i] = 8'h00;
	end
	// ==========================================
	// mode decode, one modelling clock per step
	always @(posedge clk) begin
		tog <= !tog;
		pcs <= !cs;
		if (busy != 0)
			busy <= busy - 1; // pins ignored
		else if (inh)
			inh <= !line; // standby until line high
		else if (!line) begin // save only when dirty
			inh <= 1;
			hw <= 1;
			kpos <= 0;
			// a write already under way lands before the copy
			if (cs && !pins.write_n)
				mem[a] = wdata;
			if (dirty || (cs && !pins.write_n)) begin
				nvm = mem;
				dirty <= 0;
				busy <= SAVE_CYC;
				saves <= saves + 1;
			end
		end else begin
			if (cs && !pins.write_n) begin // byte write
				mem[a] <= wdata;
				dirty <= 1;
				kpos <= 0; // a write breaks the key run
			end
			if (pcs && cs) begin // keys ignore oe
				wfirst <= !pins.write_n;
				hw <= 0;
				if (!pins.write_n)
					kpos <= 0;
				else if (kpos == 5 && a == nvc_pkg::KEY_SAVE) begin
					nvm = mem;
					dirty <= 0;
					busy <= SAVE_CYC;
					saves <= saves + 1;
					kpos <= 0;
				end else if (kpos == 5 && a == nvc_pkg::KEY_RESTORE) begin
					mem = nvm;
					dirty <= 0;
					busy <= REST_CYC;
					rests <= rests + 1;
					kpos <= 0;
				end else
					kpos <= (kpos < 5 && a == keys[kpos]) ? kpos + 1
						: int'(a == nvc_pkg::KEY0);
			end
		end
	end
endmodule : nvc_dev_model

// [sim/test_nvc_host.sv]
// testbench: host controller against the device model
`timescale 1ns/1ps
module test_nvc_host;
	logic               sys_clk = 0, sys_rst = 1, req_valid = 0;
	logic               hw_save_req = 0, wlow = 0;
	nvc_pkg::nvc_req_t  req = '0;
	logic               req_ready, rsp_valid, nv_busy, data_oe, pull;
	logic               hsb_o, hsb_oe;
	logic [7:0]         rsp_rdata, data_o, data_i;
	nvc_pkg::nvc_pins_t pins;
	logic [7:0]         mm [8192];
	logic [7:0]         shadow [8192];
	logic [12:0]        ad [8];
	logic [31:0]        r;
	int                 mismatches = 0, n_tests = 0, seed = 11183;
	int                 exp_s = 0, exp_r = 0, k;
	wire                line = !(hsb_oe && !hsb_o) && !pull;
	// ==========================================
	// clock, parts and monitors
	always #50 sys_clk = !sys_clk;
	nvc_host #(.SAVE_WAIT(50), .RESTORE_WAIT(20)) dut (.sys_clk(sys_clk),
		.sys_rst(sys_rst), .req_valid(req_valid), .req(req),
		.hw_save_req(hw_save_req), .req_ready(req_ready),
		.rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .nv_busy(nv_busy),
		.pins(pins), .data_i(data_i), .data_o(data_o), .data_oe(data_oe),
		.hw_save_busy_n_i(line), .hw_save_busy_n_o(hsb_o),
		.hw_save_busy_n_oe(hsb_oe));
	nvc_dev_model dev (.clk(sys_clk), .pins(pins), .wdata(data_o),
		.wdata_oe(data_oe), .line(line), .bus(data_i), .pull(pull));
	// a write strobe inside a key operation is latched here
	always @(posedge sys_clk)
		if (req.op[1] && !pins.write_n && !sys_rst)
			wlow <= 1;
	task automatic check(input string what, input logic [31:0] seen, exp);
		n_tests++;
		if (seen !== exp) begin
			mismatches++;
			$display("MISMATCH %s exp %h seen %h", what, exp, seen);
		end
	endtask : check
	task automatic give_verdict();
		if (mismatches == 0 && n_tests > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : give_verdict
	// bounded wait for the controller to accept work again
	task automatic idle_wait();
		for (k = 0; k < 3000 && req_ready !== 1'b1; k++)
			@(negedge sys_clk);
		check("ready", k < 3000, 1);
		if (k == 3000)
			give_verdict();
	endtask : idle_wait
	// one request, held for one taking edge, then the reference update
	task automatic op(input nvc_pkg::nvc_op_t o, input logic [12:0] a,
		input logic [7:0] d, input bit chk = 1);
		idle_wait();
		req_valid = 1;
		req = '{o, a, d};
		@(negedge sys_clk);
		req_valid = 0;
		for (k = 0; k < 100 && rsp_valid !== 1'b1; k++)
			@(negedge sys_clk);
		check("rsp", k < 100, 1);
		if (k == 100)
			give_verdict();
		if (o == nvc_pkg::NVC_OP_READ && chk)
			check("rdata", rsp_rdata, mm[a]); // data back
		else if (o == nvc_pkg::NVC_OP_WRITE)
			mm[a] = d;
		else if (o == nvc_pkg::NVC_OP_SW_SAVE) begin
			shadow = mm;
			exp_s++;
		end else if (o == nvc_pkg::NVC_OP_SW_REST) begin
			mm = shadow;
			exp_r++;
		end
	endtask : op
	// ==========================================
	// main sequence
	initial begin
		foreach (mm[i]) mm[i] = 8'h00;
		repeat (2) @(negedge sys_clk);
		check("rst", {pins.chip_sel_n, pins.write_n, data_oe, hsb_oe}, 4'hc); // idle pins
		sys_rst = 0;
		for (int i = 0; i < 8; i++) begin
			r = $random(seed);
			ad[i] = r[12:0];
			op(nvc_pkg::NVC_OP_WRITE, ad[i], r[20:13]); // writes
		end
		for (int i = 0; i < 8; i++)
			op(nvc_pkg::NVC_OP_READ, ad[i], 8'h00); // reads
		op(nvc_pkg::NVC_OP_SW_SAVE, 13'h0000, 8'h00);
		check("saves", dev.saves, exp_s); // key save
		op(nvc_pkg::NVC_OP_WRITE, ad[0], ~mm[ad[0]]);
		op(nvc_pkg::NVC_OP_SW_REST, 13'h0000, 8'h00);
		check("rests", dev.rests, exp_r); // key restore
		op(nvc_pkg::NVC_OP_READ, ad[0], 8'h00); // restored byte
		check("wlow", wlow, 0); // strobe stays high
		// plain key reads: first spoiled by a write, then clean
		for (int j = 0; j < 2; j++) begin
			for (int i = 0; i < 6; i++) begin
				if (j == 0 && i == 3)
					op(nvc_pkg::NVC_OP_WRITE, 13'h0123, 8'h5a);
				op(nvc_pkg::NVC_OP_READ, i < 5 ? dev.keys[i]
					: nvc_pkg::KEY_SAVE, 8'h00, i < 5);
			end
			if (j == 1) begin
				exp_s++;
				shadow = mm;
			end
			check("saves", dev.saves, exp_s); // abort first, then save
		end
		for (k = 0; k < 100 && dev.busy != 0; k++)
			@(negedge sys_clk);
		check("dev_busy", k < 100, 1); // save ends
		if (k == 100)
			give_verdict();
		// hardware save, first with nothing written since the last one
		for (int j = 0; j < 2; j++) begin
			if (j == 1)
				op(nvc_pkg::NVC_OP_WRITE, ad[1], 8'h3c);
			idle_wait();
			hw_save_req = 1;
			@(negedge sys_clk);
			hw_save_req = 0;
			@(negedge sys_clk);
			check("pull", hsb_oe & ~hsb_o, 1); // request pulse
			check("busy", {nv_busy, req_ready}, 2'b10); // held off
			idle_wait();
			exp_s += j;
			if (j == 1)
				shadow = mm;
			check("saves", dev.saves, exp_s); // dirty only
		end
		op(nvc_pkg::NVC_OP_READ, ad[1], 8'h00); // inhibit gone
		give_verdict();
	end
	// hang guard
	initial begin
		repeat (100000) @(posedge sys_clk);
		mismatches++;
		give_verdict();
	end
endmodule : test_nvc_host

// [src/nvc_host.sv]
// file: host-side controller for a battery-free nonvolatile static memory
// Operation
// - keep write and save lines high on reads
// - save line high on writes; address stable
// - write strobe high through key sequence
// - hold save request low 15 ns minimum
// - key addresses for save and restore
`timescale 1ns/1ps
module nvc_host #(
	parameter int unsigned SAVE_WAIT    = nvc_pkg::SAVE_CYC,
	parameter int unsigned RESTORE_WAIT = nvc_pkg::RESTORE_CYC
) (
	input  wire logic              sys_clk,
	input  wire logic              sys_rst,
	input  wire logic              req_valid,
	input  wire nvc_pkg::nvc_req_t req,
	input  wire logic              hw_save_req,
	output logic                   req_ready,
	output logic                   rsp_valid,
	output logic [7:0]             rsp_rdata,
	output logic                   nv_busy,
	output nvc_pkg::nvc_pins_t     pins,
	input  wire logic [7:0]        data_i,
	output logic [7:0]             data_o,
	output logic                   data_oe,
	input  wire logic              hw_save_busy_n_i,
	output logic                   hw_save_busy_n_o,
	output logic                   hw_save_busy_n_oe
);

	// ======================================================================
	// types and state
	typedef enum logic [2:0] {
		NVC_IDLE   = 3'b000,
		NVC_SETUP  = 3'b001,
		NVC_STROBE = 3'b010,
		NVC_END    = 3'b011,
		NVC_NVWAIT = 3'b100,
		NVC_HWPULL = 3'b101,
		NVC_HWWAIT = 3'b110,
		NVC_RECOV  = 3'b111
	} nvc_state_t;

	nvc_state_t        state;
	nvc_pkg::nvc_req_t cur;
	logic [2:0]        key_idx;
	logic [3:0]        phase;
	logic [nvc_pkg::CNT_W-1:0] wait_cnt;
	logic              busy_s1;
	logic              busy_s2;

	// address of the n-th key read for the chosen operation
	function automatic logic [12:0] nvc_key(input logic [2:0] idx,
		input logic restore);
		case (idx)
			3'd0: nvc_key = nvc_pkg::KEY0;
			3'd1: nvc_key = nvc_pkg::KEY1;
			3'd2: nvc_key = nvc_pkg::KEY2;
			3'd3: nvc_key = nvc_pkg::KEY3;
			3'd4: nvc_key = nvc_pkg::KEY4;
			default: nvc_key = restore ? nvc_pkg::KEY_RESTORE
				: nvc_pkg::KEY_SAVE;
		endcase
	endfunction : nvc_key

	function automatic logic nvc_is_key(input nvc_pkg::nvc_op_t op);
		nvc_is_key = (op == nvc_pkg::NVC_OP_SW_SAVE) ||
			(op == nvc_pkg::NVC_OP_SW_REST);
	endfunction : nvc_is_key

	// ======================================================================
	// shared busy pin synchroniser; it comes from outside the clock domain
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			busy_s1 <= 1'b1;
			busy_s2 <= 1'b1;
		end else begin
			busy_s1 <= hw_save_busy_n_i;
			busy_s2 <= busy_s1;
		end
	end

	// ======================================================================
	// main sequencer; the key sequence runs as six reads with nothing
	// interleaved, since any foreign access would abort it in the device
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			state    <= NVC_IDLE;
			cur      <= '0;
			key_idx  <= 3'd0;
			phase    <= 4'h0;
			wait_cnt <= '0;
		end else begin
			case (state)
				NVC_IDLE: begin
					key_idx <= 3'd0;
					phase   <= 4'h0;
					if (hw_save_req) begin
						state    <= NVC_HWPULL; // save line only while idle
						wait_cnt <= '0;
					end else if (!busy_s2) begin
						state    <= NVC_HWWAIT; // another party saves
					end else if (req_valid) begin
						cur   <= req;
						state <= NVC_SETUP;
					end
				end
				NVC_SETUP: begin
					// address loads on the edge that lowers select; write strobe stays high
					phase <= phase + 4'h1;
					if (phase + 4'h1 >= nvc_pkg::ACC_SETUP_CYC) begin
						phase <= 4'h0;
						state <= NVC_STROBE;
					end
				end
				NVC_STROBE: begin
					phase <= phase + 4'h1;
					if (phase + 4'h1 >= nvc_pkg::ACC_STROBE_CYC) begin
						phase <= 4'h0;
						state <= NVC_END;
					end
				end
				NVC_END: begin
					if (nvc_is_key(cur.op) && key_idx != 3'd5) begin
						key_idx <= key_idx + 3'd1;
						state   <= NVC_SETUP;
					end else if (nvc_is_key(cur.op)) begin
						wait_cnt <= '0;
						state    <= NVC_NVWAIT;
					end else begin
						state <= NVC_IDLE;
					end
				end
				NVC_NVWAIT: begin
					// device is deaf until the cycle ends
					wait_cnt <= wait_cnt + 1'b1;
					if (cur.op == nvc_pkg::NVC_OP_SW_REST ?
						wait_cnt + 1'b1 >= nvc_pkg::CNT_W'(RESTORE_WAIT) :
						wait_cnt + 1'b1 >= nvc_pkg::CNT_W'(SAVE_WAIT))
						state <= NVC_IDLE;
				end
				NVC_HWPULL: begin
					// hold low a fixed count: pulse minimum plus busy latency plus two cycles
					wait_cnt <= wait_cnt + 1'b1;
					if (wait_cnt + 1'b1 >= nvc_pkg::CNT_W'(
						nvc_pkg::SAVE_PULSE_CYC + nvc_pkg::BUSY_LAT_CYC + 2))
						state <= NVC_HWWAIT;
				end
				NVC_HWWAIT: begin
					wait_cnt <= '0;
					if (busy_s2)
						state <= NVC_RECOV; // save done or skipped
				end
				NVC_RECOV: begin
					// inhibit lifts after the line rises
					wait_cnt <= wait_cnt + 1'b1;
					if (wait_cnt + 1'b1 >= nvc_pkg::CNT_W'(nvc_pkg::RECOVER_CYC))
						state <= NVC_IDLE;
				end
				default: state <= NVC_IDLE;
			endcase
		end
	end

	// ======================================================================
	// memory pins; output enable low on all reads, key reads too, since a key read starts
	// its nonvolatile cycle whatever it shows
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			pins    <= '{chip_sel_n: 1'b1, write_n: 1'b1, out_en_n: 1'b1,
				byte_addr: '0};
			data_o  <= 8'h00;
			data_oe <= 1'b0;
		end else begin
			pins.chip_sel_n <= !((state == NVC_SETUP &&
				phase + 4'h1 >= nvc_pkg::ACC_SETUP_CYC) ||
				(state == NVC_STROBE &&
				phase + 4'h1 < nvc_pkg::ACC_STROBE_CYC));
			// write strobe never low on key reads or when select opens with
			// it, so the data bus is never left floating by mistake
			pins.write_n <= !(cur.op == nvc_pkg::NVC_OP_WRITE &&
				state == NVC_STROBE &&
				phase + 4'h1 < nvc_pkg::ACC_STROBE_CYC);
			pins.out_en_n <= !(cur.op != nvc_pkg::NVC_OP_WRITE &&
				(state == NVC_SETUP || state == NVC_STROBE));
			if (state == NVC_SETUP)
				pins.byte_addr <= nvc_is_key(cur.op) ?
					nvc_key(key_idx, cur.op == nvc_pkg::NVC_OP_SW_REST) :
					cur.addr;
			data_o  <= cur.wdata;
			data_oe <= cur.op == nvc_pkg::NVC_OP_WRITE &&
				(state == NVC_SETUP || state == NVC_STROBE);
		end
	end

	// ======================================================================
	// shared save line: open drain, only pulled low
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			hw_save_busy_n_o  <= 1'b1;
			hw_save_busy_n_oe <= 1'b0;
		end else begin
			hw_save_busy_n_o  <= 1'b0;
			hw_save_busy_n_oe <= (state == NVC_IDLE && hw_save_req) ||
				(state == NVC_HWPULL && wait_cnt + 1'b1 < nvc_pkg::CNT_W'(
				nvc_pkg::SAVE_PULSE_CYC + nvc_pkg::BUSY_LAT_CYC + 2));
		end
	end

	// ======================================================================
	// user-side answers
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			req_ready <= 1'b0;
			rsp_valid <= 1'b0;
			rsp_rdata <= 8'h00;
			nv_busy   <= 1'b0;
		end else begin
			req_ready <= state == NVC_IDLE && !hw_save_req && busy_s2 &&
				!req_valid;
			rsp_valid <= state == NVC_END &&
				(!nvc_is_key(cur.op) || key_idx == 3'd5);
			if (state == NVC_STROBE && cur.op == nvc_pkg::NVC_OP_READ)
				rsp_rdata <= data_i;
			nv_busy <= state == NVC_NVWAIT || state == NVC_HWPULL ||
				state == NVC_HWWAIT || state == NVC_RECOV;
		end
	end

	// ======================================================================
	// checks
	write_off_read_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		!pins.out_en_n |-> pins.write_n && !hw_save_busy_n_oe)
		else $error("write or save asserted during read");
	write_key_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		nvc_is_key(cur.op) && state != NVC_IDLE |-> pins.write_n)
		else $error("write strobe low in key sequence");
	save_pulse_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		$rose(hw_save_busy_n_oe) |-> hw_save_busy_n_oe[*4])
		else $error("save request too short");
	addr_stable_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		!pins.chip_sel_n && !pins.write_n |=> $stable(pins.byte_addr)
		|| pins.chip_sel_n || pins.write_n)
		else $error("address moved during write");
	key_first_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		state == NVC_STROBE && nvc_is_key(cur.op) && key_idx == 3'd0
		|-> pins.byte_addr == nvc_pkg::KEY0)
		else $error("key sequence start address wrong");
	recov_len_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		$rose(state == NVC_RECOV) |-> (state == NVC_RECOV)[*7]
		##1 state == NVC_IDLE)
		else $error("recovery wait wrong length");
	no_access_busy_a: assert property (@(posedge sys_clk)
		disable iff (sys_rst) nv_busy |-> pins.chip_sel_n)
		else $error("access while nonvolatile cycle runs");
	rsp_after_write_a: assert property (@(posedge sys_clk)
		disable iff (sys_rst) !pins.write_n |-> ##[1:3] rsp_valid)
		else $error("write not answered");
	sw_save_c: cover property (@(posedge sys_clk) disable iff (sys_rst)
		state == NVC_NVWAIT && cur.op == nvc_pkg::NVC_OP_SW_SAVE);
	sw_rest_c: cover property (@(posedge sys_clk) disable iff (sys_rst)
		state == NVC_NVWAIT && cur.op == nvc_pkg::NVC_OP_SW_REST);
	hw_save_c: cover property (@(posedge sys_clk) disable iff (sys_rst)
		state == NVC_RECOV);

endmodule : nvc_host

// [src/nvc_pkg.sv]
// package: constants and types for the nonvolatile memory host controller
package nvc_pkg;

	localparam int unsigned CLK_PERIOD_NS = 100;

	// timing figures in their own units
	localparam int unsigned SAVE_REQUEST_PULSE_MIN_NS = 15;
	localparam int unsigned SAVE_BUSY_LATENCY_NS      = 300;
	localparam int unsigned CYCLE_FINISH_ALLOWANCE_US = 1;
	localparam int unsigned INHIBIT_RELEASE_TIME_NS   = 700;
	localparam int unsigned NV_SAVE_DURATION_MS       = 10;
	localparam int unsigned RESTORE_DURATION_US       = 20;

	// derived cycle counts: least times round up, longest round down
	localparam int unsigned SAVE_PULSE_CYC =
		(SAVE_REQUEST_PULSE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned BUSY_LAT_CYC =
		SAVE_BUSY_LATENCY_NS / CLK_PERIOD_NS;
	localparam int unsigned RECOVER_CYC =
		INHIBIT_RELEASE_TIME_NS / CLK_PERIOD_NS;
	localparam int unsigned ALLOWANCE_CYC =
		(CYCLE_FINISH_ALLOWANCE_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned SAVE_CYC =
		(NV_SAVE_DURATION_MS * 1000000) / CLK_PERIOD_NS;
	localparam int unsigned RESTORE_CYC =
		(RESTORE_DURATION_US * 1000) / CLK_PERIOD_NS;

	// access strobe timing, cycles of sys_clk
	localparam logic [3:0] ACC_SETUP_CYC  = 4'h1;
	localparam logic [3:0] ACC_STROBE_CYC = 4'h2;

	localparam int unsigned ADDR_W  = 13;
	localparam int unsigned DATA_W  = 8;
	localparam int unsigned CNT_W   = 20;

	// software save/restore key sequence
	localparam logic [12:0] KEY0       = 13'h0000;
	localparam logic [12:0] KEY1       = 13'h1555;
	localparam logic [12:0] KEY2       = 13'h0aaa;
	localparam logic [12:0] KEY3       = 13'h1fff;
	localparam logic [12:0] KEY4       = 13'h10f0;
	localparam logic [12:0] KEY_SAVE   = 13'h0f0f;
	localparam logic [12:0] KEY_RESTORE = 13'h0f0e;

	typedef enum logic [1:0] {
		NVC_OP_READ    = 2'b00,
		NVC_OP_WRITE   = 2'b01,
		NVC_OP_SW_SAVE = 2'b10,
		NVC_OP_SW_REST = 2'b11
	} nvc_op_t;

	// a request from the user side
	typedef struct packed {
		nvc_op_t           op;
		logic [12:0]       addr;
		logic [7:0]        wdata;
	} nvc_req_t;

	// memory pins driven by the controller (strobes active low)
	typedef struct packed {
		logic        chip_sel_n;
		logic        write_n;
		logic        out_en_n;
		logic [12:0] byte_addr;
	} nvc_pins_t;

endpackage : nvc_pkg
